// ==== rtl/hla_consts.svh ====
// constants for the host link acknowledge and fallback block
// ----------------------------------------------------------
// ----------------------------------------------------------
`ifndef HLA_CONSTS_SVH
`define HLA_CONSTS_SVH
`define HLA_REG_CTRL 8'h00
`define HLA_REG_TMO 8'h04
`define HLA_REG_RETRY 8'h08
`define HLA_REG_FALLBK 8'h0C
`define HLA_REG_FMT 8'h10
`define HLA_REG_PRESET 8'h14
`define HLA_REG_STS 8'h18
`define HLA_REG_MASK 8'h1C
`define HLA_REG_STATE 8'h20
`define HLA_CTRL_RST 5'h04
`define HLA_TMO_RST 16'h07D0
`define HLA_FB_MIN_RST 6'h05
`define HLA_CHR_ACK 8'h06
`define HLA_CHR_NAK 8'h15
`define HLA_CHR_BEL 8'h07
`define HLA_CHR_CAN 8'h18
`define HLA_CLK_HZ 200000000
`define HLA_MS_PER_MIN 60000
`define HLA_EV_DONE 0
`define HLA_EV_ABANDON 1
`define HLA_EV_TIMEOUT 2
`define HLA_EV_FALLBK 3
`define HLA_EV_BELL 4
`endif

// ==== rtl/hla_pkg.sv ====
// types for the host link acknowledge and fallback block
package hla_pkg;
  typedef enum logic [1:0] {BAUD_1200, BAUD_2400, BAUD_9600, BAUD_38400} hla_baud_e;
  typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD, PAR_MARK} hla_par_e;
  typedef enum logic [1:0] {FLOW_OFF, FLOW_MSG_NOTMO, FLOW_CHR_TMO, FLOW_MSG_TMO} hla_flow_e;
  typedef enum logic [1:0] {SUF_NONE, SUF_CR, SUF_LF, SUF_CRLF} hla_suf_e;
  typedef enum logic [2:0] {PRE_NONE, PRE_FUEL1, PRE_FUEL2, PRE_BIOPTIC, PRE_BIOPTIC3, PRE_USBSER} hla_pre_e;
  typedef enum {ST_IDLE, ST_WAIT} hla_st_e;
  typedef struct packed {
    logic usb_serial;
    hla_suf_e suffix;
    hla_flow_e flow;
    logic stop2;
    hla_par_e parity;
    logic data8;
    hla_baud_e baud;
  } hla_fmt_s;
  typedef struct packed {
    logic [1:0] alt_mode;
    logic beep_en;
    logic bel_can;
    logic ack_mode;
  } hla_ctrl_s;
endpackage : hla_pkg

// ==== rtl/hla_top.sv ====
// host link acknowledge/retry, usb keyboard fallback, presets and alt keystrokes
//
// Register access over Avalon-MM and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "hla_consts.svh"
module hla_top
  import hla_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = `HLA_CLK_HZ / 1000,
  parameter int unsigned MS_PER_MIN = `HLA_MS_PER_MIN
)(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic msg_start,
  input wire logic msg_is_config,
  output logic msg_busy,
  output logic tx_send,
  output logic config_apply,
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  input wire logic usb_setup_ok,
  output logic kbd_fallback,
  output logic beep_error,
  output logic beep_fb_enter,
  output logic beep_fb_reject,
  output hla_fmt_s link_fmt,
  input wire logic ext_valid,
  input wire logic [7:0] ext_code,
  output logic ext_ready,
  output logic alt_hold,
  output logic key_valid,
  output logic [3:0] key_digit,
  output logic irq
);
  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    hla_ctrl_s ctrl;
    logic [15:0] tmo_ms;
    logic [7:0] to_lim;
    logic [7:0] nak_lim;
    logic [5:0] fb_min;
    logic usb_sel;
    hla_fmt_s fmt;
    logic [4:0] sts;
    logic [4:0] mask;
    hla_st_e st;
    logic [31:0] ms_div;
    logic [15:0] timer;
    logic [7:0] to_cnt;
    logic [7:0] nak_cnt;
    logic [31:0] min_div;
    logic [5:0] minutes;
    logic fallback;
    logic tx_send;
    logic cfg;
    logic b_err;
    logic b_fbe;
    logic b_fbr;
    logic alt_busy;
    logic [2:0] alt_idx;
    logic [7:0] alt_code;
    logic key_valid;
    logic [3:0] key_digit;
  } hla_state_s;

  hla_state_s r, next_r;
  logic [1:0] rst_sync;
  logic rst_n;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        m[i*8 +: 8] = wd[i*8 +: 8];
    return m;
  endfunction : be_merge

  // decimal digit of code at position pos (3 is always zero for 4-digit mode)
  function automatic logic [3:0] dec_digit(input logic [7:0] code, input logic [2:0] pos);
    logic [7:0] d;
    case (pos)
      3'h0: d = code % 8'd10;
      3'h1: d = (code / 8'd10) % 8'd10;
      3'h2: d = code / 8'd100;
      default: d = 8'h00;
    endcase
    return d[3:0];
  endfunction : dec_digit

  logic req, wr_go, ms_tick, min_tick, tmo_hit;
  logic [31:0] wv;
  assign req = avs_read | avs_write;
  assign wr_go = avs_write & r.ack;
  assign ms_tick = (r.ms_div == CYC_PER_MS - 1);
  assign min_tick = ms_tick && (r.min_div == MS_PER_MIN - 1);

  always_comb
  begin
    next_r = r;
    wv = 32'h0;
    tmo_hit = 1'b0;
    next_r.tx_send = 1'b0;
    next_r.cfg = 1'b0;
    next_r.b_err = 1'b0;
    next_r.b_fbe = 1'b0;
    next_r.b_fbr = 1'b0;
    next_r.key_valid = 1'b0;
    // ----------------------------------------------------------
    // avalon slave: one wait cycle, read data latched on the first
    // ----------------------------------------------------------
    next_r.ack = req & ~r.ack;
    if (avs_read && !r.ack)
    begin
      case (avs_address)
        `HLA_REG_CTRL: next_r.rdata = {27'h0, r.ctrl};
        `HLA_REG_TMO: next_r.rdata = {16'h0, r.tmo_ms};
        `HLA_REG_RETRY: next_r.rdata = {16'h0, r.nak_lim, r.to_lim};
        `HLA_REG_FALLBK: next_r.rdata = {23'h0, r.usb_sel, 2'h0, r.fb_min};
        `HLA_REG_FMT: next_r.rdata = {21'h0, r.fmt};
        `HLA_REG_STS: next_r.rdata = {27'h0, r.sts};
        `HLA_REG_MASK: next_r.rdata = {27'h0, r.mask};
        `HLA_REG_STATE: next_r.rdata = {r.nak_cnt, r.to_cnt, 2'h0, r.minutes, 6'h0, r.fallback,
                                         (r.st == ST_WAIT)};
        default: next_r.rdata = 32'h0;
      endcase
    end
    if (wr_go)
    begin
      case (avs_address)
        `HLA_REG_CTRL:
        begin
          wv = be_merge({27'h0, r.ctrl}, avs_writedata, avs_byteenable);
          next_r.ctrl = wv[4:0];
        end
        `HLA_REG_TMO:
        begin
          wv = be_merge({16'h0, r.tmo_ms}, avs_writedata, avs_byteenable);
          next_r.tmo_ms = wv[15:0];
        end
        `HLA_REG_RETRY:
        begin
          wv = be_merge({16'h0, r.nak_lim, r.to_lim}, avs_writedata, avs_byteenable);
          next_r.to_lim = wv[7:0];
          next_r.nak_lim = wv[15:8];
        end
        `HLA_REG_FALLBK:
        begin
          wv = be_merge({23'h0, r.usb_sel, 2'h0, r.fb_min}, avs_writedata, avs_byteenable);
          next_r.fb_min = (wv[5:0] > 6'd60) ? 6'd60 : wv[5:0];
          next_r.usb_sel = wv[8];
        end
        `HLA_REG_FMT:
        begin
          wv = be_merge({21'h0, r.fmt}, avs_writedata, avs_byteenable);
          next_r.fmt = wv[10:0];
        end
        `HLA_REG_PRESET:
          if (avs_byteenable[0])
          begin
            case (hla_pre_e'(avs_writedata[2:0]))
              PRE_FUEL1: next_r.fmt = '{1'b0, SUF_LF, FLOW_MSG_NOTMO, 1'b0, PAR_MARK, 1'b1, BAUD_1200};
              PRE_FUEL2: next_r.fmt = '{1'b0, SUF_CR, FLOW_OFF, 1'b1, PAR_EVEN, 1'b0, BAUD_2400};
              PRE_BIOPTIC:
              begin
                next_r.fmt = '{1'b0, r.fmt.suffix, FLOW_CHR_TMO, 1'b0, PAR_NONE, 1'b1, BAUD_38400};
                next_r.ctrl.ack_mode = 1'b1;
              end
              PRE_BIOPTIC3: next_r.fmt = '{1'b0, r.fmt.suffix, FLOW_MSG_TMO, 1'b0, PAR_EVEN, 1'b0, BAUD_9600};
              PRE_USBSER:
              begin
                next_r.fmt.usb_serial = 1'b1;
                next_r.fmt.suffix = SUF_CRLF;
                next_r.usb_sel = 1'b1;
              end
              default: ;
            endcase
          end
        `HLA_REG_MASK:
          if (avs_byteenable[0])
            next_r.mask = avs_writedata[4:0];
        default: ;
      endcase
    end
    // write-one-to-clear first; events below set and so win
    if (wr_go && avs_address == `HLA_REG_STS && avs_byteenable[0])
      next_r.sts = r.sts & ~avs_writedata[4:0];
    // ----------------------------------------------------------
    // timebase
    // ----------------------------------------------------------
    next_r.ms_div = ms_tick ? 32'h0 : r.ms_div + 32'h1;
    // ----------------------------------------------------------
    // usb keyboard fallback; a setting of zero disables it
    // ----------------------------------------------------------
    if (!r.usb_sel || usb_setup_ok || r.fallback)
    begin
      next_r.min_div = 32'h0;
      next_r.minutes = 6'h0;
    end
    else if (ms_tick)
    begin
      next_r.min_div = min_tick ? 32'h0 : r.min_div + 32'h1;
      if (min_tick)
        next_r.minutes = r.minutes + 6'h1;
    end
    if (!r.fallback && r.usb_sel && !usb_setup_ok && r.fb_min != 6'h0 && r.minutes >= r.fb_min)
    begin
      next_r.fallback = 1'b1;
      next_r.b_fbe = 1'b1;
      next_r.sts[`HLA_EV_FALLBK] = 1'b1;
    end
    if (!r.usb_sel)
      next_r.fallback = 1'b0;
    // ----------------------------------------------------------
    // message and reply handling
    // ----------------------------------------------------------
    case (r.st)
      ST_IDLE:
        if (msg_start)
        begin
          if (msg_is_config)
            next_r.cfg = 1'b1;
          else if (r.fallback)
            next_r.b_fbr = 1'b1;
          else
          begin
            next_r.tx_send = 1'b1;
            next_r.to_cnt = 8'h0;
            next_r.nak_cnt = 8'h0;
            if (r.ctrl.ack_mode)
            begin
              next_r.st = ST_WAIT;
              next_r.timer = r.tmo_ms;
            end
            else
              next_r.sts[`HLA_EV_DONE] = 1'b1;
          end
        end
      ST_WAIT:
      begin
        if (ms_tick && r.timer != 16'h0)
          next_r.timer = r.timer - 16'h1;
        tmo_hit = (r.timer == 16'h0);
        if (rx_valid && rx_char == `HLA_CHR_ACK)
        begin
          next_r.st = ST_IDLE;
          next_r.sts[`HLA_EV_DONE] = 1'b1;
        end
        else if (rx_valid && rx_char == `HLA_CHR_NAK)
        begin
          if (r.nak_lim == 8'h0 || r.nak_cnt < r.nak_lim)
          begin
            next_r.tx_send = 1'b1;
            next_r.nak_cnt = r.nak_cnt + 8'h1;
            next_r.timer = r.tmo_ms;
          end
          else
          begin
            next_r.st = ST_IDLE;
            next_r.sts[`HLA_EV_ABANDON] = 1'b1;
          end
        end
        else if (rx_valid && r.ctrl.bel_can && rx_char == `HLA_CHR_CAN)
        begin
          next_r.st = ST_IDLE;
          next_r.sts[`HLA_EV_ABANDON] = 1'b1;
        end
        else if (tmo_hit)
        begin
          next_r.sts[`HLA_EV_TIMEOUT] = 1'b1;
          next_r.b_err = r.ctrl.beep_en;
          if (r.to_cnt < r.to_lim)
          begin
            next_r.tx_send = 1'b1;
            next_r.to_cnt = r.to_cnt + 8'h1;
            next_r.timer = r.tmo_ms;
          end
          else
          begin
            next_r.st = ST_IDLE;
            next_r.sts[`HLA_EV_ABANDON] = 1'b1;
          end
        end
      end
      default: next_r.st = ST_IDLE;
    endcase
    if (r.st == ST_WAIT && rx_valid && r.ctrl.bel_can && rx_char == `HLA_CHR_BEL)
    begin
      next_r.b_err = 1'b1;
      next_r.sts[`HLA_EV_BELL] = 1'b1;
    end
    // ----------------------------------------------------------
    // alt keystrokes: most significant digit first, one per cycle
    // ----------------------------------------------------------
    if (!r.alt_busy)
    begin
      if (ext_valid && (r.ctrl.alt_mode == 2'h1 || r.ctrl.alt_mode == 2'h2))
      begin
        next_r.alt_busy = 1'b1;
        next_r.alt_code = ext_code;
        next_r.alt_idx = (r.ctrl.alt_mode == 2'h2) ? 3'h4 : 3'h3;
      end
    end
    else if (r.alt_idx != 3'h0)
    begin
      next_r.key_valid = 1'b1;
      next_r.key_digit = dec_digit(r.alt_code, r.alt_idx - 3'h1);
      next_r.alt_idx = r.alt_idx - 3'h1;
    end
    else
      next_r.alt_busy = 1'b0;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.ctrl <= `HLA_CTRL_RST;
      r.tmo_ms <= `HLA_TMO_RST;
      r.fb_min <= `HLA_FB_MIN_RST;
      r.fmt <= '{1'b0, SUF_NONE, FLOW_OFF, 1'b0, PAR_NONE, 1'b1, BAUD_9600};
      r.st <= ST_IDLE;
    end
    else
      r <= next_r;
  end

  assign avs_waitrequest = req & ~r.ack;
  assign avs_readdata = r.rdata;
  assign msg_busy = (r.st == ST_WAIT);
  assign tx_send = r.tx_send;
  assign config_apply = r.cfg;
  assign kbd_fallback = r.fallback;
  assign beep_error = r.b_err;
  assign beep_fb_enter = r.b_fbe;
  assign beep_fb_reject = r.b_fbr;
  assign link_fmt = r.fmt;
  assign ext_ready = ~r.alt_busy;
  assign alt_hold = r.alt_busy;
  assign key_valid = r.key_valid;
  assign key_digit = r.key_digit;
  assign irq = |(r.sts & r.mask);

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  fb_entry_beep_a: assert property ($rose(kbd_fallback) |-> beep_fb_enter)
    else $error("fallback entered without beep");
  fb_cause_a: assert property ($rose(kbd_fallback) |-> $past(r.usb_sel) && !$past(usb_setup_ok))
    else $error("fallback without failed usb setup");
  fb_drop_a: assert property (kbd_fallback && msg_start && !msg_is_config && !msg_busy
                              |=> beep_fb_reject && !tx_send)
    else $error("symbol data not dropped in fallback");
  cfg_apply_a: assert property (msg_start && msg_is_config && !msg_busy |=> config_apply)
    else $error("config symbol not applied");
  ack_end_a: assert property (msg_busy && rx_valid && rx_char == `HLA_CHR_ACK |=> !msg_busy && !tx_send)
    else $error("ack did not end wait");
  nak_resend_a: assert property (msg_busy && rx_valid && rx_char == `HLA_CHR_NAK && r.nak_lim == 8'h0
                                 |=> tx_send && msg_busy)
    else $error("nak did not resend");
  tmo_beep_a: assert property (msg_busy && r.timer == 16'h0 && !rx_valid && r.ctrl.beep_en |=> beep_error)
    else $error("timeout without error beep");
  tmo_zero_a: assert property (msg_busy && r.timer == 16'h0 && !rx_valid && r.to_lim == 8'h0
                               |=> !msg_busy && !tx_send)
    else $error("zero retries did not abandon");
  can_end_a: assert property (msg_busy && rx_valid && rx_char == `HLA_CHR_CAN && r.ctrl.bel_can
                              |=> !msg_busy)
    else $error("cancel did not end transmission");
  alt_len_a: assert property ($rose(alt_hold) && r.alt_idx == 3'h3 |=> key_valid [*3] ##1 !key_valid)
    else $error("alt mode digit count wrong");
  wait_one_a: assert property (req && !r.ack |=> !avs_waitrequest || !req)
    else $error("bus answer late");

  nak_seen_c: cover property (msg_busy && rx_valid && rx_char == `HLA_CHR_NAK);
  tmo_retry_c: cover property (msg_busy && r.timer == 16'h0 ##1 tx_send);
  fb_enter_c: cover property ($rose(kbd_fallback));
endmodule : hla_top
`default_nettype wire

// ==== tb/hla_host_model.sv ====
// host terminal model answering each transmission from a reply queue
`timescale 1ns/1ps
`default_nettype none
`include "hla_consts.svh"
module hla_host_model
  import hla_pkg::*;
(
  input wire logic core_clk,
  input wire logic tx_send,
  input wire logic [7:0] gap,
  output logic rx_valid,
  output logic [7:0] rx_char
);
  logic [7:0] replies[$];
  logic [7:0] c;

  // ----------------------------------------------------------
  // one reply character after a programmable gap
  // ----------------------------------------------------------
  task automatic put(input logic [7:0] v);
    repeat (gap) @(posedge core_clk);
    rx_valid <= 1'b1;
    rx_char <= v;
    @(posedge core_clk);
    rx_valid <= 1'b0;
    // idle line must not keep showing the last character
    rx_char <= ~v;
  endtask : put

  initial
  begin
    rx_valid = 1'b0;
    rx_char = 8'h00;
    forever
    begin
      @(posedge core_clk);
      if (tx_send === 1'b1 && replies.size() != 0)
      begin
        c = replies.pop_front();
        // 00h stands for a host that stays silent
        if (c != 8'h00)
          put(c);
        // bell asks no resend, so the next queued reply follows it
        if (c == `HLA_CHR_BEL && replies.size() != 0)
          put(replies.pop_front());
      end
    end
  end
endmodule : hla_host_model
`default_nettype wire

// ==== tb/host_link_acknak_fallback_test.sv ====
// self-checking bench for the host link acknowledge and fallback block
`timescale 1ns/1ps
`default_nettype none
`include "hla_consts.svh"
module host_link_acknak_fallback_test
  import hla_pkg::*;
;
  localparam logic [10:0] PM [1:5] = '{11'h3FF, 11'h33F, 11'h0FF, 11'h0FF, 11'h700};
  localparam logic [10:0] PE [1:5] = '{11'h25C, 11'h129, 11'h087, 11'h0CA, 11'h700};
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic msg_start = 1'b0;
  logic msg_is_config = 1'b0;
  logic usb_setup_ok = 1'b1;
  logic ext_valid = 1'b0;
  logic [7:0] ext_code = 8'h00;
  logic [7:0] gap = 8'h02;
  logic msg_busy, tx_send, config_apply, rx_valid, kbd_fallback, beep_error, beep_fb_enter, beep_fb_reject;
  logic ext_ready, alt_hold, key_valid, irq;
  logic [7:0] rx_char;
  logic [3:0] key_digit;
  hla_fmt_s link_fmt;
  int failures = 0;
  int total_checks = 0;
  int n_tx, n_beep, n_fbe, n_fbr, n_cfg, cyc, t, r;
  logic [3:0] digs[$];
  int exp_d[$];
  logic [31:0] d;
  logic [7:0] c;

  always #2.5 core_clk = ~core_clk;

  hla_top #(.CYC_PER_MS(10), .MS_PER_MIN(5)) i_dut (.core_clk(core_clk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .msg_start(msg_start), .msg_is_config(msg_is_config), .msg_busy(msg_busy), .tx_send(tx_send),
    .config_apply(config_apply), .rx_valid(rx_valid), .rx_char(rx_char), .usb_setup_ok(usb_setup_ok),
    .kbd_fallback(kbd_fallback), .beep_error(beep_error), .beep_fb_enter(beep_fb_enter),
    .beep_fb_reject(beep_fb_reject), .link_fmt(link_fmt), .ext_valid(ext_valid), .ext_code(ext_code),
    .ext_ready(ext_ready), .alt_hold(alt_hold), .key_valid(key_valid), .key_digit(key_digit), .irq(irq));

  hla_host_model i_host (.core_clk(core_clk), .tx_send(tx_send), .gap(gap), .rx_valid(rx_valid),
    .rx_char(rx_char));

  // ----------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge core_clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    bus(1'b1, a, wd, x);
  endtask : wr

  task automatic waitlow(ref logic s);
    cyc = 0;
    while (s !== 1'b0 && cyc < 3000)
    begin
      @(posedge core_clk);
      cyc++;
    end
    // a wait that runs out is a mismatch, not a silent pass
    chk(cyc < 3000, 1, "wait limit");
  endtask : waitlow

  task automatic pulse(input logic cfg);
    msg_start <= 1'b1;
    msg_is_config <= cfg;
    @(posedge core_clk);
    msg_start <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : pulse

  // one message in acknowledge mode, then counts and status
  task automatic run(input int etx, input int ebp, input logic [31:0] ests);
    n_tx = 0;
    n_beep = 0;
    msg_start <= 1'b1;
    @(posedge core_clk);
    msg_start <= 1'b0;
    @(posedge core_clk);
    waitlow(msg_busy);
    repeat (2) @(posedge core_clk);
    chk(n_tx, etx, "sends");
    chk(n_beep, ebp, "error beeps");
    bus(1'b0, `HLA_REG_STS, 0, d);
    chk(d, ests, "status");
    wr(`HLA_REG_STS, 32'h1F);
  endtask : run

  always @(posedge core_clk)
  begin
    if (tx_send === 1'b1) n_tx++;
    if (beep_error === 1'b1) n_beep++;
    if (beep_fb_enter === 1'b1) n_fbe++;
    if (beep_fb_reject === 1'b1) n_fbr++;
    if (config_apply === 1'b1) n_cfg++;
    if (key_valid === 1'b1)
    begin
      digs.push_back(key_digit);
      chk(alt_hold, 1, "alt held over keys");
    end
  end

  initial
  begin
    repeat (40000) @(posedge core_clk);
    $display("[FAIL] %0t watchdog expired", $time);
    failures++;
    stop_test();
  end

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial
  begin
    void'($urandom(32'h61A9));
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    bus(1'b0, `HLA_REG_CTRL, 0, d);
    chk(d, 32'h4, "ctrl reset");
    bus(1'b0, `HLA_REG_TMO, 0, d);
    chk(d, 32'h7D0, "timeout reset");
    bus(1'b0, `HLA_REG_RETRY, 0, d);
    chk(d, 32'h0, "retry reset");
    bus(1'b0, `HLA_REG_FALLBK, 0, d);
    chk(d, 32'h5, "fallback reset");
    bus(1'b0, 8'h40, 0, d);
    chk(d, 32'h0, "unmapped read");
    for (int p = 1; p <= 5; p++)
    begin
      wr(`HLA_REG_PRESET, p);
      bus(1'b0, `HLA_REG_FMT, 0, d);
      chk(d & PM[p], PE[p], "preset register");
      chk(link_fmt & PM[p], PE[p], "preset port");
      bus(1'b0, `HLA_REG_CTRL, 0, d);
      chk(d[0], p >= 3, "ack mode");
    end
    t = $urandom % 2048;
    wr(`HLA_REG_FMT, t);
    bus(1'b0, `HLA_REG_FMT, 0, d);
    chk(d, t, "format readback");
    chk(link_fmt, t, "format port");
    wr(`HLA_REG_CTRL, 32'h5);
    wr(`HLA_REG_TMO, 20);
    gap <= 8'(1 + $urandom % 6);
    i_host.replies = {`HLA_CHR_ACK};
    run(1, 0, 32'h1);
    wr(`HLA_REG_RETRY, 32'h200);
    i_host.replies = {`HLA_CHR_NAK, `HLA_CHR_NAK, `HLA_CHR_NAK};
    run(3, 0, 32'h2);
    wr(`HLA_REG_RETRY, 0);
    i_host.replies = {`HLA_CHR_NAK, `HLA_CHR_NAK, `HLA_CHR_NAK, `HLA_CHR_NAK, `HLA_CHR_ACK};
    run(5, 0, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      t = $urandom % 4;
      r = $urandom % 3;
      wr(`HLA_REG_TMO, t);
      wr(`HLA_REG_RETRY, r);
      i_host.replies = {};
      run(r + 1, r + 1, 32'h6);
      chk(cyc >= (r + 1) * (t * 10 - 10) && cyc <= (r + 1) * (t * 10 + 10) + 10, 1, "wait span");
    end
    wr(`HLA_REG_TMO, 2);
    wr(`HLA_REG_RETRY, 1);
    i_host.replies = {8'h00, `HLA_CHR_ACK};
    run(2, 1, 32'h5);
    wr(`HLA_REG_CTRL, 32'h1);
    wr(`HLA_REG_RETRY, 0);
    run(1, 0, 32'h6);
    wr(`HLA_REG_CTRL, 32'h7);
    wr(`HLA_REG_TMO, 50);
    i_host.replies = {`HLA_CHR_BEL, `HLA_CHR_CAN};
    run(1, 1, 32'h12);
    chk(cyc < 100, 1, "cancel ends early");
    wr(`HLA_REG_CTRL, 32'h5);
    i_host.replies = {`HLA_CHR_BEL, `HLA_CHR_ACK};
    run(1, 0, 32'h1);
    // fallback: setup held off, then one entry, rejects and config
    wr(`HLA_REG_MASK, 32'h8);
    wr(`HLA_REG_FALLBK, 32'h102);
    usb_setup_ok <= 1'b0;
    n_fbe = 0;
    cyc = 0;
    while (kbd_fallback !== 1'b1 && cyc < 400)
    begin
      @(posedge core_clk);
      cyc++;
    end
    chk(cyc >= 50 && cyc <= 130, 1, "fallback time");
    repeat (2) @(posedge core_clk);
    chk(n_fbe, 1, "entry beep");
    chk(irq, 1, "irq raised");
    bus(1'b0, `HLA_REG_STATE, 0, d);
    chk(d, 32'h2, "state in fallback");
    n_tx = 0;
    n_fbr = 0;
    n_cfg = 0;
    pulse(1'b0);
    chk(n_fbr, 1, "reject beep");
    chk(n_tx, 0, "no send in fallback");
    pulse(1'b1);
    chk(n_cfg, 1, "config applied");
    wr(`HLA_REG_MASK, 0);
    chk(irq, 0, "irq masked");
    wr(`HLA_REG_MASK, 32'h8);
    chk(irq, 1, "irq unmasked");
    wr(`HLA_REG_STS, 32'h8);
    chk(irq, 0, "irq cleared");
    wr(`HLA_REG_FALLBK, 32'h5);
    usb_setup_ok <= 1'b1;
    // alt mode off: extended characters are not taken
    digs.delete();
    ext_valid <= 1'b1;
    ext_code <= 8'hC8;
    repeat (8) @(posedge core_clk);
    ext_valid <= 1'b0;
    chk(digs.size(), 0, "alt off ignores");
    for (int m = 1; m <= 2; m++)
    begin
      c = 8'(128 + $urandom % 128);
      exp_d.delete();
      digs.delete();
      if (m == 2) exp_d.push_back(0);
      exp_d.push_back(c / 100);
      exp_d.push_back((c / 10) % 10);
      exp_d.push_back(c % 10);
      wr(`HLA_REG_CTRL, 32'(m) << 3);
      ext_valid <= 1'b1;
      ext_code <= c;
      @(posedge core_clk);
      while (ext_ready !== 1'b1)
        @(posedge core_clk);
      ext_valid <= 1'b0;
      repeat (2) @(posedge core_clk);
      waitlow(alt_hold);
      chk(digs.size(), exp_d.size(), "digit count");
      foreach (exp_d[i]) chk(digs[i], exp_d[i], "digit");
    end
    stop_test();
  end
endmodule : host_link_acknak_fallback_test
`default_nettype wire
